// ### timer_clock_enable_remap_ctrl.sv
// Purpose: apb slave producing watchdog and timer enables, remap control
// Assumes: reference clocks arrive as asynchronous pins
// Notes: zero-wait-state apb; each access phase lasts one cycle
//   each enable has its own small select-and-register cell below
//   enables lag a control write by two cycles and a pin edge by three
//   only reset brings remapping back once software has cleared it
//
// Functional notes
// - first watchdog enable follows slow reference unless override forces high
// - timers 0..3 enable from reference select unless override forces high
// - timers 0..3 select: clear picks slow reference, set picks fast clock
// - remap status bit is read-only and shows remapping is active
// - writing one to remap clear bit ends remapping, normal mapping
// - second watchdog enable follows slow reference unless override set
// - timers 4..7 enable from reference select unless override forces high
// - timers 4..7 select: clear picks slow reference, set picks fast
// - control registers answer at 0x10001000 and 0x1001a000
// - only control and identification registers; identification gives build version
`timescale 1ns/100ps

module timer_clock_enable_remap_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_reference_clock,
	input wire logic fast_timer_clock,
	output logic [1:0] wdog_enable,
	output logic [7:0] timer_enable,
	output logic remap_active
);

	////////////////////////////////////////////////////////////////////////
	// reference clock synchronisers and edge detect

	logic [1:0] ref_sync1_r;
	logic [1:0] ref_sync2_r;
	logic [1:0] ref_prev_r;
	logic [1:0] ref_rise;
	logic slow_pulse;
	logic fast_pulse;

	// index 0 slow, index 1 fast; first stage read by second stage only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_sync1_r <= 2'h0;
			ref_sync2_r <= 2'h0;
			ref_prev_r <= 2'h0;
		end else begin
			ref_sync1_r <= {fast_timer_clock, slow_reference_clock};
			ref_sync2_r <= ref_sync1_r;
			ref_prev_r <= ref_sync2_r;
		end
	end

	// one pulse per rising edge, fast clock is 1/200 of pclk so no loss
	assign ref_rise = ref_sync2_r & ~ref_prev_r;
	assign slow_pulse = ref_rise[0];
	assign fast_pulse = ref_rise[1];

	////////////////////////////////////////////////////////////////////////
	// apb register file

	logic [31:0] ctrl_a_r, ctrl_a_nxt;
	logic [31:0] ctrl_b_r, ctrl_b_nxt;
	logic remap_r, remap_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic setup;
	logic wr_commit;
	logic hit_a, hit_b, hit_id;
	logic [31:0] status_a;

	assign setup = psel && !penable && !pready_r;
	assign wr_commit = psel && penable && pready_r && pwrite;
	assign hit_a = (paddr == sysctl_pkg::ADDR_CTRL_A);
	assign hit_b = (paddr == sysctl_pkg::ADDR_CTRL_B);
	assign hit_id = (paddr == sysctl_pkg::ADDR_ID_A) ||
		(paddr == sysctl_pkg::ADDR_ID_B);

	// remap bits are not stored; status reflects live remap state
	always_comb begin
		status_a = ctrl_a_r;
		status_a[sysctl_pkg::REMAP_STAT_BIT] = remap_r;
		status_a[sysctl_pkg::REMAP_CLR_BIT] = 1'b0;
	end

	// bus next state: answer computed in setup, write done in access
	always_comb begin
		ctrl_a_nxt = ctrl_a_r;
		ctrl_b_nxt = ctrl_b_r;
		remap_nxt = remap_r;
		prdata_nxt = prdata_r;
		pready_nxt = setup;
		pslverr_nxt = 1'b0;
		if (setup) begin
			pslverr_nxt = !(hit_a || hit_b || hit_id);
			if (pwrite)
				prdata_nxt = 32'h00000000;
			else if (hit_a)
				prdata_nxt = status_a;
			else if (hit_b)
				prdata_nxt = ctrl_b_r;
			else if (hit_id)
				prdata_nxt = sysctl_pkg::BUILD_VERSION;
			else
				prdata_nxt = 32'h00000000;
		end
		// reserved bits stored so read-modify-write keeps them
		if (wr_commit && hit_a) begin
			ctrl_a_nxt = pwdata;
			ctrl_a_nxt[sysctl_pkg::REMAP_STAT_BIT] = 1'b0;
			ctrl_a_nxt[sysctl_pkg::REMAP_CLR_BIT] = 1'b0;
			if (pwdata[sysctl_pkg::REMAP_CLR_BIT])
				remap_nxt = 1'b0;
		end
		if (wr_commit && hit_b)
			ctrl_b_nxt = pwdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_a_r <= sysctl_pkg::CTRL_RESET;
			ctrl_b_r <= sysctl_pkg::CTRL_RESET;
			remap_r <= sysctl_pkg::REMAP_RESET;
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_a_r <= ctrl_a_nxt;
			ctrl_b_r <= ctrl_b_nxt;
			remap_r <= remap_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign remap_active = remap_r;

	////////////////////////////////////////////////////////////////////////
	// enable generation

	// one cell per enable; override forces high, else chosen pulse
	// watchdogs have no select, so they always take the slow pulse
	// timer i: override at select position plus one
	// first register feeds timers 0..3, second feeds timers 4..7
	// every cell registers its output, so pins come from flops
	// a select change mid-pulse only moves the next pulse, no glitch

	// first watchdog
	enable_select u_wdog0 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_a_r[sysctl_pkg::WDOG_OVR_BIT]),
		.pick_fast(1'b0),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(wdog_enable[0])
	);

	// second watchdog
	enable_select u_wdog1 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_b_r[sysctl_pkg::WDOG_OVR_BIT]),
		.pick_fast(1'b0),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(wdog_enable[1])
	);

	// timer 0
	enable_select u_timer0 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 1]),
		.pick_fast(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[0])
	);

	// timer 1
	enable_select u_timer1 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 3]),
		.pick_fast(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 2]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[1])
	);

	// timer 2
	enable_select u_timer2 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 5]),
		.pick_fast(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 4]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[2])
	);

	// timer 3
	enable_select u_timer3 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 7]),
		.pick_fast(ctrl_a_r[sysctl_pkg::TIMER_SEL_LSB + 6]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[3])
	);

	// timer 4
	enable_select u_timer4 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 1]),
		.pick_fast(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[4])
	);

	// timer 5
	enable_select u_timer5 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 3]),
		.pick_fast(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 2]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[5])
	);

	// timer 6
	enable_select u_timer6 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 5]),
		.pick_fast(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 4]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[6])
	);

	// timer 7
	enable_select u_timer7 (
		.pclk(pclk),
		.presetn(presetn),
		.force_high(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 7]),
		.pick_fast(ctrl_b_r[sysctl_pkg::TIMER_SEL_LSB + 6]),
		.slow_pulse(slow_pulse),
		.fast_pulse(fast_pulse),
		.enable(timer_enable[7])
	);

endmodule : timer_clock_enable_remap_ctrl

////////////////////////////////////////////////////////////////////////////
// one enable output: forced high or pulsed by the chosen reference

module enable_select (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic force_high,
	input wire logic pick_fast,
	input wire logic slow_pulse,
	input wire logic fast_pulse,
	output logic enable
);

	logic enable_r, enable_nxt;

	// a level from override, otherwise one pulse per reference edge
	always_comb begin
		enable_nxt = force_high | (pick_fast ? fast_pulse : slow_pulse);
	end

	// registered so the pin never glitches while the select changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_r <= 1'b0;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	assign enable = enable_r;

endmodule : enable_select

// ### sysctl_pkg.sv
// Purpose: shared constants for the timer clock enable and remap control
// Assumes: apb byte addresses, 32-bit data, one aligned word per register
// Notes: both control registers live in one slave at two address windows
package sysctl_pkg;

	// register byte addresses
	localparam logic [31:0] ADDR_CTRL_A = 32'h10001000;
	localparam logic [31:0] ADDR_CTRL_B = 32'h1001a000;
	localparam logic [31:0] ADDR_ID_A = 32'h10001fe0;
	localparam logic [31:0] ADDR_ID_B = 32'h1001afe0;

	// build version word; the value is arbitrary
	localparam logic [31:0] BUILD_VERSION = 32'h00000001;

	// field positions
	localparam int WDOG_OVR_BIT = 23;
	localparam int TIMER_SEL_LSB = 15; // select at 15+2i, override at 16+2i
	localparam int REMAP_STAT_BIT = 9;
	localparam int REMAP_CLR_BIT = 8;
	localparam int TIMERS_PER_INST = 4;

	// reset values
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	localparam logic REMAP_RESET = 1'b1;

endpackage : sysctl_pkg

// ### timer_clock_enable_remap_ctrl_properties.sv
// Purpose: port properties of the enable and remap slave
// Assumes: zero-wait apb; enables settle within two cycles of a write
// Notes: attached to the design by bind
`timescale 1ns/100ps
module timer_clock_enable_remap_ctrl_properties (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] wdog_enable,
	input wire logic [7:0] timer_enable,
	input wire logic remap_active
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////
	// completed transfers, split by register
	wire acc = psel && penable && pready;
	wire wa = acc && pwrite && paddr == sysctl_pkg::ADDR_CTRL_A;
	wire wb = acc && pwrite && paddr == sysctl_pkg::ADDR_CTRL_B;
	wire ra = acc && !pwrite && paddr == sysctl_pkg::ADDR_CTRL_A;
	wire map = paddr inside {sysctl_pkg::ADDR_CTRL_A, sysctl_pkg::ADDR_CTRL_B,
		sysctl_pkg::ADDR_ID_A, sysctl_pkg::ADDR_ID_B};
	////////////////////////////////////////////////////////////////////////
	// overrides force enables high shortly after the commit edge
	property p_wd0; wa && pwdata[23] |-> ##[1:2] wdog_enable[0];
	endproperty
	a_wd0: assert property (p_wd0) else $error("wd0 not forced");
	property p_wd1; wb && pwdata[23] |-> ##[1:2] wdog_enable[1];
	endproperty
	a_wd1: assert property (p_wd1) else $error("wd1 not forced");
	property p_t0; wa && pwdata[16] |-> ##[1:2] timer_enable[0];
	endproperty
	a_t0: assert property (p_t0) else $error("t0 not forced");
	property p_t7; wb && pwdata[22] |-> ##[1:2] timer_enable[7];
	endproperty
	a_t7: assert property (p_t7) else $error("t7 not forced");
	// remap leaves once and only reset brings it back
	property p_rm1; wa && pwdata[8] |-> ##[1:2] !remap_active;
	endproperty
	a_rm1: assert property (p_rm1) else $error("remap kept");
	property p_rm2; !remap_active |=> !remap_active;
	endproperty
	a_rm2: assert property (p_rm2) else $error("remap back");
	property p_st; ra |-> prdata[9] == remap_active && !prdata[8];
	endproperty
	a_st: assert property (p_st) else $error("status bad");
	property p_err; acc |-> pslverr == !map;
	endproperty
	a_err: assert property (p_err) else $error("decode bad");
	c_clr: cover property (wa && pwdata[8]);
	c_wb: cover property (wb);
	c_err: cover property (acc && pslverr);
endmodule : timer_clock_enable_remap_ctrl_properties
bind timer_clock_enable_remap_ctrl
	timer_clock_enable_remap_ctrl_properties u_props (.*);

// ### timer_clock_enable_remap_ctrl_bench.sv
// Purpose: self-checking bench for the enable and remap slave
// Assumes: zero-wait apb master, reference pins driven in bursts
// Notes: reference pins stay low between bursts
`timescale 1ns/100ps
`define CHK(g, x) begin tests_run++; if ((g) !== (x)) begin errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, x); end end
module timer_clock_enable_remap_ctrl_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic slow = 0, fast = 0, pready, pslverr, remap_active, e;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic [1:0] wdog_enable;
	logic [7:0] timer_enable;
	logic [9:0] fm = 10'h081;
	wire [9:0] ens = {wdog_enable, timer_enable};
	int errors = 0, tests_run = 0, cyc = 0, cnt[10];
	always #2.5 pclk = ~pclk;
	timer_clock_enable_remap_ctrl u_dut (.slow_reference_clock(slow),
		.fast_timer_clock(fast), .*);
	// counted off the sampling edge, so no race with the design
	always @(negedge pclk) foreach (cnt[i]) cnt[i] += ens[i];
	always @(posedge pclk) if (++cyc == 20000) begin errors++; wrap_up(); end
	////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rd(input logic [31:0] a, x);
		apb(0, a, 32'h00000000);
		`CHK(r, x)
	endtask : rd
	// n rising edges on one reference pin, then let pulses drain
	task automatic refs(input logic s, input int n);
		repeat (8) @(posedge pclk);
		cnt = '{default: 0};
		repeat (n) begin
			repeat (8) @(posedge pclk);
			{slow, fast} <= {s, !s};
			repeat (8) @(posedge pclk);
			{slow, fast} <= 2'b00;
		end
		repeat (8) @(posedge pclk);
	endtask : refs
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(sysctl_pkg::ADDR_CTRL_A, 32'h00000200);
		rd(sysctl_pkg::ADDR_CTRL_B, 32'h00000000);
		rd(sysctl_pkg::ADDR_ID_B, sysctl_pkg::BUILD_VERSION);
		rd(32'h10001004, 32'h00000000);
		`CHK(e, 1'b1)
		$display("reset test done");
		apb(1, sysctl_pkg::ADDR_CTRL_A, 32'hff007c00);
		rd(sysctl_pkg::ADDR_CTRL_A, 32'hff007e00);
		apb(1, sysctl_pkg::ADDR_CTRL_B, 32'hff007fff);
		rd(sysctl_pkg::ADDR_CTRL_B, 32'hff007fff);
		apb(1, sysctl_pkg::ADDR_CTRL_A, 32'h00d50000);
		apb(1, sysctl_pkg::ADDR_CTRL_B, 32'h00d50000);
		repeat (2) @(negedge pclk);
		`CHK(ens, 10'h3ff)
		$display("override test done");
		apb(1, sysctl_pkg::ADDR_CTRL_A, 32'h00008000);
		apb(1, sysctl_pkg::ADDR_CTRL_B, 32'h00200000);
		refs(0, 3);
		foreach (cnt[i]) `CHK(cnt[i], fm[i] ? 3 : 0)
		refs(1, 2);
		foreach (cnt[i]) `CHK(cnt[i], fm[i] ? 0 : 2)
		$display("select test done");
		apb(1, sysctl_pkg::ADDR_CTRL_A, 32'h00000300);
		rd(sysctl_pkg::ADDR_CTRL_A, 32'h00000000);
		`CHK(remap_active, 1'b0)
		$display("remap test done");
		wrap_up();
	end
endmodule : timer_clock_enable_remap_ctrl_bench
